/* common/psm_consts.vh */
`ifndef PSM_CONSTS_VH
`define PSM_CONSTS_VH

// ==================================================
// Register byte addresses (one 32-bit word each)
`define PSM_ADDR_GPIO_EN 8'h00
`define PSM_ADDR_GPIO_DIR 8'h04
`define PSM_ADDR_GPIO_OUT 8'h08
`define PSM_ADDR_GPIO_IN 8'h0C
`define PSM_ADDR_PERIPH_CFG 8'h10
`define PSM_ADDR_STATUS 8'h14

// ==================================================
// Field positions in the peripheral config register
`define PSM_CFG_VIDEO1_BIT 0
`define PSM_CFG_AUDIO0_BIT 1
`define PSM_CFG_ETH_BIT 2

// ==================================================
// Field positions in the status register
`define PSM_ST_HOST_SEL_BIT 0
`define PSM_ST_ETH_ACTIVE_BIT 1
`define PSM_ST_VIDEO1_OWN_BIT 2
`define PSM_ST_AUDIO0_OWN_BIT 3

// ==================================================
// GPIO bank layout
`define PSM_GPIO_W 16
`define PSM_GPIO_CLK4_BIT 1
`define PSM_GPIO_CLK6_BIT 2
`define PSM_GPIO_VCXO_BIT 8
`define PSM_GPIO_PCI_LO 9
`define PSM_GPIO_PCI_HI 15
`define PSM_PCI_SHARED_W 7
// Only enable bits of pins that really sit on a shared pad are writable
`define PSM_GPIO_EN_MASK 16'hFF06

// ==================================================
// Widths of the other pin groups
`define PSM_AV_W 8
`define PSM_PCI_SOLO_W 8

// ==================================================
// Reset values
`define PSM_RST_GPIO_EN 16'h0000
`define PSM_RST_GPIO_DIR 16'h0000
`define PSM_RST_GPIO_OUT 16'h0000
`define PSM_RST_CFG 3'h0

`endif

/* design/psm_strap_latch.v */
`timescale 1ns/1ns
`default_nettype none

module psm_strap_latch (
   input wire clk_i,
   input wire rst_i,
   input wire strap_i,
   output wire latched_o
);

   reg latched;

   // ==================================================
   // Strap capture
   // Follows the pull level only while reset is held; frozen after release
   always @(posedge clk_i) begin
      if (rst_i) begin
         latched <= strap_i;
      end
   end

   assign latched_o = latched;

endmodule // psm_strap_latch

`default_nettype wire

/* design/psm_pad_sel.v */
`timescale 1ns/1ns
`default_nettype none

module psm_pad_sel (
   input wire sel_a_i,
   input wire sel_b_i,
   input wire a_out_i,
   input wire a_oe_i,
   input wire b_out_i,
   input wire b_oe_i,
   input wire pad_in_i,
   output wire pad_out_o,
   output wire pad_oe_o,
   output wire a_in_o,
   output wire b_in_o
);

   wire own_a;
   wire own_b;

   // ==================================================
   // Ownership: source a wins a double enable, so one driver only
   assign own_a = sel_a_i;
   assign own_b = sel_b_i & ~sel_a_i;

   // Pad drive; no owner leaves the pad floating
   assign pad_out_o = own_a ? a_out_i : (own_b ? b_out_i : 1'b0);
   assign pad_oe_o = own_a ? a_oe_i : (own_b ? b_oe_i : 1'b0);

   // Non-owners see a quiet zero, not the other function's traffic
   assign a_in_o = own_a & pad_in_i;
   assign b_in_o = own_b & pad_in_i;

endmodule // psm_pad_sel

`default_nettype wire

/* design/psm_top.v */
// What this block does
// - The host-bus select is taken from the strap pin only while reset is held and ignores the pin afterwards.
// - Each strap-selected pin group has at most one owning function after reset.
// - After reset both clock pins drive the divided CPU clocks and become GPIO only once their enable bits are set.
// - A set GPIO enable bit gives the pin to GPIO (pins 8..15 only at host-bus select 0), whose direction bit makes it an input at 0 and an output at 1.
// - After reset the GPIO 8 pin carries the VCXO control output with its enable and the Ethernet enable cleared.
// - GPIO 8 takes its pin only while the host-bus select is 0 and its enable bit is set, direction picking in or out.
// - GPIO 15..9 act as GPIO only while the host-bus select is 0 and their enables are set, direction picking in or out.
// - After reset the eight video/audio shared pins carry neither function and both enable bits are 0.
// - With the video 1 enable set the eight pins carry video 1 data bits 19..12 and the audio data stays off.
// - With only the audio 0 enable set the eight pins carry audio serial data 7..0 and the video 1 data stays off.
// - While the host-bus select is 0 every stand-alone PCI pin is tied off and floats.
// - The host-bus select reads 0 for PCI off (default) and 1 for PCI on and chooses PCI against the other functions.
// - The Ethernet enable reads 0 by default, 1 when set, and does nothing while the host-bus select is 1.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "psm_consts.vh"

module psm_top (
   input wire clk_i,
   input wire rst_i,
   // Wishbone classic slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   // Strap for the host-bus select
   input wire strap_host_bus_sel_i,
   // Internal function sources
   input wire cpu_div4_clock_out_i,
   input wire cpu_div6_clock_out_i,
   input wire vcxo_control_output_i,
   // Clock-output pads
   input wire pad_clk4_i,
   output wire pad_clk4_o,
   output wire pad_clk4_oe_o,
   input wire pad_clk6_i,
   output wire pad_clk6_o,
   output wire pad_clk6_oe_o,
   // VCXO / GPIO 8 pad
   input wire pad_gp8_i,
   output wire pad_gp8_o,
   output wire pad_gp8_oe_o,
   // PCI / GPIO 15..9 pads and PCI core side
   input wire [`PSM_PCI_SHARED_W-1:0] pad_pci_gpio_i,
   output wire [`PSM_PCI_SHARED_W-1:0] pad_pci_gpio_o,
   output wire [`PSM_PCI_SHARED_W-1:0] pad_pci_gpio_oe_o,
   input wire [`PSM_PCI_SHARED_W-1:0] pci_shared_out_i,
   input wire [`PSM_PCI_SHARED_W-1:0] pci_shared_oe_i,
   output wire [`PSM_PCI_SHARED_W-1:0] pci_shared_in_o,
   // Stand-alone PCI pads and PCI core side
   input wire [`PSM_PCI_SOLO_W-1:0] pad_pci_solo_i,
   output wire [`PSM_PCI_SOLO_W-1:0] pad_pci_solo_o,
   output wire [`PSM_PCI_SOLO_W-1:0] pad_pci_solo_oe_o,
   input wire [`PSM_PCI_SOLO_W-1:0] pci_solo_out_i,
   input wire [`PSM_PCI_SOLO_W-1:0] pci_solo_oe_i,
   output wire [`PSM_PCI_SOLO_W-1:0] pci_solo_in_o,
   // Video 1 upper data / audio 0 serial data pads
   input wire [`PSM_AV_W-1:0] pad_av_i,
   output wire [`PSM_AV_W-1:0] pad_av_o,
   output wire [`PSM_AV_W-1:0] pad_av_oe_o,
   input wire [`PSM_AV_W-1:0] video1_data_pins_out_i,
   input wire [`PSM_AV_W-1:0] video1_data_pins_oe_i,
   output wire [`PSM_AV_W-1:0] video1_data_pins_in_o,
   input wire [`PSM_AV_W-1:0] audio0_serial_data_pins_out_i,
   input wire [`PSM_AV_W-1:0] audio0_serial_data_pins_oe_i,
   output wire [`PSM_AV_W-1:0] audio0_serial_data_pins_in_o,
   // Peripheral enables towards the core
   output wire pci_enable_o,
   output wire host_port_enable_o,
   output wire ethernet_enable_o,
   output wire video1_data_enable_o,
   output wire audio0_data_enable_o
);

   // ==================================================
   // Register state
   reg [`PSM_GPIO_W-1:0] gpio_pin_enable_bit;
   reg [`PSM_GPIO_W-1:0] gpio_pin_direction_bit;
   reg [`PSM_GPIO_W-1:0] gpio_out;
   reg [`PSM_GPIO_W-1:0] gpio_in;
   reg video1_data_enable;
   reg audio0_data_enable;
   reg ethernet_enable_bit;
   reg ack;
   reg [31:0] rd_data;
   reg [31:0] next_rd_data;
   reg [`PSM_GPIO_W-1:0] next_gpio_in;

   wire host_sel;
   wire req;
   wire wr_stb;
   wire [7:0] word_adr;
   wire [`PSM_GPIO_W-1:0] lane_mask;
   wire [`PSM_GPIO_W-1:0] wr_half;
   wire gpio1_enable_bit;
   wire gpio2_enable_bit;
   wire gpio8_enable_bit;
   wire gpio8_direction_bit;
   wire own_gp1;
   wire own_gp2;
   wire own_gp8;
   wire [`PSM_PCI_SHARED_W-1:0] own_gp_pci;
   wire [`PSM_PCI_SHARED_W-1:0] pci_en_en;
   wire [`PSM_PCI_SHARED_W-1:0] pci_en_dir;
   wire [`PSM_PCI_SHARED_W-1:0] pci_en_out;
   wire [`PSM_AV_W-1:0] av_video_sel;
   wire [`PSM_AV_W-1:0] av_audio_sel;

   // ==================================================
   // Host-bus select strap
   psm_strap_latch u_strap (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .strap_i(strap_host_bus_sel_i),
      .latched_o(host_sel)
   );

   // PCI against host port, MAC, management and GPIO
   assign pci_enable_o = host_sel;
   assign host_port_enable_o = ~host_sel;

   // ==================================================
   // Wishbone decode
   assign req = wb_cyc_i & wb_stb_i;
   assign wr_stb = req & wb_we_i & ~ack;
   assign word_adr = {wb_adr_i[7:2], 2'b00};
   // Only the two low byte lanes carry register bits
   assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wr_half = wb_dat_i[15:0];

   // Ack one cycle after the request, dropped the next cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   assign wb_ack_o = ack;

   // ==================================================
   // GPIO registers
   // Unmasked enable bits have no pad behind them, so they stay 0
   always @(posedge clk_i) begin
      if (rst_i) begin
         gpio_pin_enable_bit <= `PSM_RST_GPIO_EN;
         gpio_pin_direction_bit <= `PSM_RST_GPIO_DIR;
         gpio_out <= `PSM_RST_GPIO_OUT;
      end else if (wr_stb) begin
         if (word_adr == `PSM_ADDR_GPIO_EN) begin
            gpio_pin_enable_bit <= (gpio_pin_enable_bit & ~lane_mask)
               | (wr_half & lane_mask & `PSM_GPIO_EN_MASK);
         end
         if (word_adr == `PSM_ADDR_GPIO_DIR) begin
            gpio_pin_direction_bit <= (gpio_pin_direction_bit & ~lane_mask) | (wr_half & lane_mask);
         end
         if (word_adr == `PSM_ADDR_GPIO_OUT) begin
            gpio_out <= (gpio_out & ~lane_mask) | (wr_half & lane_mask);
         end
      end
   end

   // ==================================================
   // Peripheral config register
   // Changing these at run time glitches the pads; set once at boot
   always @(posedge clk_i) begin
      if (rst_i) begin
         video1_data_enable <= 1'b0;
         audio0_data_enable <= 1'b0;
         ethernet_enable_bit <= 1'b0;
      end else if (wr_stb && (word_adr == `PSM_ADDR_PERIPH_CFG) && wb_sel_i[0]) begin
         video1_data_enable <= wb_dat_i[`PSM_CFG_VIDEO1_BIT];
         audio0_data_enable <= wb_dat_i[`PSM_CFG_AUDIO0_BIT];
         ethernet_enable_bit <= wb_dat_i[`PSM_CFG_ETH_BIT];
      end
   end

   // MAC stays powered down while PCI owns the shared pins
   assign ethernet_enable_o = ethernet_enable_bit & ~host_sel;
   // Video wins a double enable
   assign video1_data_enable_o = video1_data_enable;
   assign audio0_data_enable_o = audio0_data_enable & ~video1_data_enable;

   // ==================================================
   // Clock-output pads
   assign gpio1_enable_bit = gpio_pin_enable_bit[`PSM_GPIO_CLK4_BIT];
   assign gpio2_enable_bit = gpio_pin_enable_bit[`PSM_GPIO_CLK6_BIT];
   assign own_gp1 = gpio1_enable_bit;
   assign own_gp2 = gpio2_enable_bit;

   // Divided clock by default, GPIO only once enabled
   assign pad_clk4_o = own_gp1 ? gpio_out[`PSM_GPIO_CLK4_BIT] : cpu_div4_clock_out_i;
   assign pad_clk4_oe_o = own_gp1 ? gpio_pin_direction_bit[`PSM_GPIO_CLK4_BIT] : 1'b1;
   assign pad_clk6_o = own_gp2 ? gpio_out[`PSM_GPIO_CLK6_BIT] : cpu_div6_clock_out_i;
   assign pad_clk6_oe_o = own_gp2 ? gpio_pin_direction_bit[`PSM_GPIO_CLK6_BIT] : 1'b1;

   // ==================================================
   // VCXO / GPIO 8 pad
   assign gpio8_enable_bit = gpio_pin_enable_bit[`PSM_GPIO_VCXO_BIT];
   assign gpio8_direction_bit = gpio_pin_direction_bit[`PSM_GPIO_VCXO_BIT];
   // PCI-enabled strap keeps GPIO 8 off the pad regardless of its enable
   assign own_gp8 = ~host_sel & gpio8_enable_bit;
   assign pad_gp8_o = own_gp8 ? gpio_out[`PSM_GPIO_VCXO_BIT] : vcxo_control_output_i;
   assign pad_gp8_oe_o = own_gp8 ? gpio8_direction_bit : 1'b1;

   // ==================================================
   // PCI / GPIO 15..9 pads
   assign pci_en_en = gpio_pin_enable_bit[`PSM_GPIO_PCI_HI:`PSM_GPIO_PCI_LO];
   assign pci_en_dir = gpio_pin_direction_bit[`PSM_GPIO_PCI_HI:`PSM_GPIO_PCI_LO];
   assign pci_en_out = gpio_out[`PSM_GPIO_PCI_HI:`PSM_GPIO_PCI_LO];
   assign own_gp_pci = {`PSM_PCI_SHARED_W{~host_sel}} & pci_en_en;

   // PCI owns all seven when strapped on; else GPIO or floating
   genvar gi;
   generate
      for (gi = 0; gi < `PSM_PCI_SHARED_W; gi = gi + 1) begin : g_pci_gpio
         assign pad_pci_gpio_o[gi] = host_sel ? pci_shared_out_i[gi]
            : (own_gp_pci[gi] & pci_en_out[gi]);
         assign pad_pci_gpio_oe_o[gi] = host_sel ? pci_shared_oe_i[gi]
            : (own_gp_pci[gi] & pci_en_dir[gi]);
         assign pci_shared_in_o[gi] = host_sel & pad_pci_gpio_i[gi];
      end
   endgenerate

   // ==================================================
   // Stand-alone PCI pads
   // Tied off and floating while PCI is strapped off
   assign pad_pci_solo_o = pci_solo_out_i & {`PSM_PCI_SOLO_W{host_sel}};
   assign pad_pci_solo_oe_o = pci_solo_oe_i & {`PSM_PCI_SOLO_W{host_sel}};
   assign pci_solo_in_o = pad_pci_solo_i & {`PSM_PCI_SOLO_W{host_sel}};

   // ==================================================
   // Video 1 upper data / audio 0 serial data pads
   // Pad n carries video data bit 12+n or audio data line n
   assign av_video_sel = {`PSM_AV_W{video1_data_enable}};
   assign av_audio_sel = {`PSM_AV_W{audio0_data_enable}};

   genvar ai;
   generate
      for (ai = 0; ai < `PSM_AV_W; ai = ai + 1) begin : g_av
         psm_pad_sel u_sel (
            .sel_a_i(av_video_sel[ai]),
            .sel_b_i(av_audio_sel[ai]),
            .a_out_i(video1_data_pins_out_i[ai]),
            .a_oe_i(video1_data_pins_oe_i[ai]),
            .b_out_i(audio0_serial_data_pins_out_i[ai]),
            .b_oe_i(audio0_serial_data_pins_oe_i[ai]),
            .pad_in_i(pad_av_i[ai]),
            .pad_out_o(pad_av_o[ai]),
            .pad_oe_o(pad_av_oe_o[ai]),
            .a_in_o(video1_data_pins_in_o[ai]),
            .b_in_o(audio0_serial_data_pins_in_o[ai])
         );
      end
   endgenerate

   // ==================================================
   // GPIO input sampling
   // Only GPIO-owned pins are sampled; others read 0 so a clock does not show up
   always @* begin
      next_gpio_in = {`PSM_GPIO_W{1'b0}};
      next_gpio_in[`PSM_GPIO_CLK4_BIT] = own_gp1 & pad_clk4_i;
      next_gpio_in[`PSM_GPIO_CLK6_BIT] = own_gp2 & pad_clk6_i;
      next_gpio_in[`PSM_GPIO_VCXO_BIT] = own_gp8 & pad_gp8_i;
      next_gpio_in[`PSM_GPIO_PCI_HI:`PSM_GPIO_PCI_LO] = own_gp_pci & pad_pci_gpio_i;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         gpio_in <= {`PSM_GPIO_W{1'b0}};
      end else begin
         gpio_in <= next_gpio_in;
      end
   end

   // ==================================================
   // Read mux
   // Unmapped addresses still ack, reading zero, so a stray read never hangs
   always @* begin
      next_rd_data = 32'h00000000;
      case (word_adr)
         `PSM_ADDR_GPIO_EN: begin
            next_rd_data[15:0] = gpio_pin_enable_bit;
         end
         `PSM_ADDR_GPIO_DIR: begin
            next_rd_data[15:0] = gpio_pin_direction_bit;
         end
         `PSM_ADDR_GPIO_OUT: begin
            next_rd_data[15:0] = gpio_out;
         end
         `PSM_ADDR_GPIO_IN: begin
            next_rd_data[15:0] = gpio_in;
         end
         `PSM_ADDR_PERIPH_CFG: begin
            next_rd_data[`PSM_CFG_VIDEO1_BIT] = video1_data_enable;
            next_rd_data[`PSM_CFG_AUDIO0_BIT] = audio0_data_enable;
            next_rd_data[`PSM_CFG_ETH_BIT] = ethernet_enable_bit;
         end
         `PSM_ADDR_STATUS: begin
            next_rd_data[`PSM_ST_HOST_SEL_BIT] = host_sel;
            next_rd_data[`PSM_ST_ETH_ACTIVE_BIT] = ethernet_enable_o;
            next_rd_data[`PSM_ST_VIDEO1_OWN_BIT] = video1_data_enable_o;
            next_rd_data[`PSM_ST_AUDIO0_OWN_BIT] = audio0_data_enable_o;
         end
         default: begin
            next_rd_data = 32'h00000000;
         end
      endcase
   end

   // Read data registered with the ack
   always @(posedge clk_i) begin
      if (rst_i) begin
         rd_data <= 32'h00000000;
      end else if (req & ~ack) begin
         rd_data <= next_rd_data;
      end
   end

   assign wb_dat_o = rd_data;

endmodule // psm_top

`default_nettype wire

/* test/psm_board.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Board side of a pad group: the pin follows the chip when it drives,
// else the far chip's level, so a released pin never echoes stale data
module psm_board #(
   parameter int W = 1
) (
   input wire logic [W-1:0] out_i,
   input wire logic [W-1:0] oe_i,
   input wire logic [W-1:0] ext_i,
   output logic [W-1:0] pad_o
);
   // Per-bit resolution of chip drive against far-side drive
   assign pad_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule // psm_board
`default_nettype wire

/* test/psm_props.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port-level checks of the pin mux
module psm_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic vcxo_control_output_i,
   input wire logic pad_gp8_o,
   input wire logic pad_gp8_oe_o,
   input wire logic [7:0] pad_pci_solo_oe_o,
   input wire logic [7:0] pci_solo_in_o,
   input wire logic [7:0] pad_av_o,
   input wire logic [7:0] pad_av_oe_o,
   input wire logic [7:0] video1_data_pins_out_i,
   input wire logic [7:0] video1_data_pins_oe_i,
   input wire logic [7:0] video1_data_pins_in_o,
   input wire logic [7:0] audio0_serial_data_pins_out_i,
   input wire logic [7:0] audio0_serial_data_pins_oe_i,
   input wire logic [7:0] audio0_serial_data_pins_in_o,
   input wire logic pci_enable_o,
   input wire logic host_port_enable_o,
   input wire logic ethernet_enable_o,
   input wire logic video1_data_enable_o,
   input wire logic audio0_data_enable_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Bus answers exactly one cycle after a taken request
   ack_in_one_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   strap_hold_a: assert property (!rst_i |=> $stable(pci_enable_o)) else $error("host select moved");
   host_inv_a: assert property (host_port_enable_o == !pci_enable_o) else $error("host enables clash");
   eth_gate_a: assert property (pci_enable_o |-> !ethernet_enable_o) else $error("ethernet on in pci");
   gp8_vcxo_a: assert property (pci_enable_o |-> pad_gp8_oe_o && pad_gp8_o == vcxo_control_output_i)
      else $error("gp8 pad left vcxo");
   solo_tie_a: assert property (!pci_enable_o |-> pad_pci_solo_oe_o == 8'h00 && pci_solo_in_o == 8'h00)
      else $error("solo pci pad not tied off");
   av_excl_a: assert property (!(video1_data_enable_o && audio0_data_enable_o))
      else $error("both av owners on");
   av_off_a: assert property (!video1_data_enable_o && !audio0_data_enable_o |-> pad_av_oe_o == 8'h00)
      else $error("av pad driven with no owner");
   av_video_a: assert property (video1_data_enable_o |-> pad_av_o == video1_data_pins_out_i
      && pad_av_oe_o == video1_data_pins_oe_i && audio0_serial_data_pins_in_o == 8'h00) else $error("video path wrong");
   av_audio_a: assert property (audio0_data_enable_o |-> pad_av_o == audio0_serial_data_pins_out_i
      && pad_av_oe_o == audio0_serial_data_pins_oe_i && video1_data_pins_in_o == 8'h00) else $error("audio path wrong");
   cover property (video1_data_enable_o);
   cover property (audio0_data_enable_o);
   cover property (pci_enable_o && wb_ack_o);
endmodule // psm_props
bind psm_top psm_props psm_props_i (.*);
`default_nettype wire

/* test/psm_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "psm_consts.vh"
module psm_top_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, pad_clk4_i, pad_clk4_o, pad_clk4_oe_o, pad_clk6_i, pad_clk6_o, pad_clk6_oe_o;
   wire pad_gp8_i, pad_gp8_o, pad_gp8_oe_o;
   logic strap_host_bus_sel_i = 1'b0, cpu_div4_clock_out_i = 1'b0, cpu_div6_clock_out_i = 1'b0;
   logic vcxo_control_output_i = 1'b1;
   wire [6:0] pad_pci_gpio_i, pad_pci_gpio_o, pad_pci_gpio_oe_o, pci_shared_in_o;
   logic [6:0] pci_shared_out_i = 7'h55, pci_shared_oe_i = 7'h2A;
   wire [7:0] pad_pci_solo_i, pad_pci_solo_o, pad_pci_solo_oe_o, pci_solo_in_o, pad_av_i, pad_av_o, pad_av_oe_o;
   wire [7:0] video1_data_pins_in_o, audio0_serial_data_pins_in_o;
   logic [7:0] pci_solo_out_i = 8'hC3, pci_solo_oe_i = 8'hF0, video1_data_pins_out_i = 8'hA5;
   logic [7:0] video1_data_pins_oe_i = 8'hFF, audio0_serial_data_pins_out_i = 8'h3C;
   logic [7:0] audio0_serial_data_pins_oe_i = 8'h0F, ext = 8'h00;
   wire pci_enable_o, host_port_enable_o, ethernet_enable_o, video1_data_enable_o, audio0_data_enable_o;
   logic [31:0] rd;
   // Byte lanes of the next bus cycle; narrowed only by the lane scenarios
   logic [3:0] sel = 4'hF;
   int err_count = 0, samples_checked = 0;
   // ==========
   // Clock, divided clock sources, device and board
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cpu_div4_clock_out_i <= ~cpu_div4_clock_out_i;
      cpu_div6_clock_out_i <= cpu_div4_clock_out_i;
      vcxo_control_output_i <= ~cpu_div6_clock_out_i;
   end
   psm_top psm_top_i (.*);
   psm_board #(.W(1)) b4_i (.out_i(pad_clk4_o), .oe_i(pad_clk4_oe_o), .ext_i(ext[0]), .pad_o(pad_clk4_i));
   psm_board #(.W(1)) b6_i (.out_i(pad_clk6_o), .oe_i(pad_clk6_oe_o), .ext_i(ext[1]), .pad_o(pad_clk6_i));
   psm_board #(.W(1)) b8_i (.out_i(pad_gp8_o), .oe_i(pad_gp8_oe_o), .ext_i(ext[2]), .pad_o(pad_gp8_i));
   psm_board #(.W(7)) bp_i (.out_i(pad_pci_gpio_o), .oe_i(pad_pci_gpio_oe_o), .ext_i(ext[6:0]), .pad_o(pad_pci_gpio_i));
   psm_board #(.W(8)) bs_i (.out_i(pad_pci_solo_o), .oe_i(pad_pci_solo_oe_o), .ext_i(ext), .pad_o(pad_pci_solo_i));
   psm_board #(.W(8)) ba_i (.out_i(pad_av_o), .oe_i(pad_av_oe_o), .ext_i(ext), .pad_o(pad_av_i));
   // ==========
   // Shared tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle; waits on ack, the watchdog bounds the wait
   task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task rdc(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0);
      chk(rd, exp);
   endtask
   // Strap flips right after release; the mux must not notice
   task do_reset(input logic s);
      @(posedge clk_i);
      rst_i <= 1'b1;
      strap_host_bus_sel_i <= s;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      strap_host_bus_sel_i <= ~s;
      @(negedge clk_i);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ==========
   // Scenarios
   task t_defaults;
      chk({pci_enable_o, host_port_enable_o}, 2'b01);
      chk({pad_clk4_oe_o, pad_clk6_oe_o, pad_gp8_oe_o, pad_gp8_o}, {3'b111, vcxo_control_output_i});
      chk({pad_clk4_o, pad_clk6_o}, {cpu_div4_clock_out_i, cpu_div6_clock_out_i});
      chk({pad_av_oe_o, video1_data_enable_o, audio0_data_enable_o, ethernet_enable_o}, 0);
      chk({pad_pci_solo_oe_o, pad_pci_solo_o, pci_solo_in_o}, 0);
      chk({pad_pci_gpio_oe_o, pci_shared_in_o}, 0);
      rdc(`PSM_ADDR_GPIO_EN, 0);
      rdc(`PSM_ADDR_PERIPH_CFG, 0);
      rdc(`PSM_ADDR_STATUS, 0);
      rdc(8'h1C, 0);
      $display("defaults done");
   endtask
   // Enable written last so no pad flips before its direction is set
   task t_gpio;
      wb(1'b1, `PSM_ADDR_GPIO_DIR, 32'h0F04);
      wb(1'b1, `PSM_ADDR_GPIO_OUT, 32'hFFFF);
      wb(1'b1, `PSM_ADDR_GPIO_EN, 32'hFFFF);
      @(negedge clk_i);
      chk({pad_clk4_oe_o, pad_clk6_oe_o, pad_clk6_o}, 3'b011);
      chk({pad_gp8_oe_o, pad_gp8_o}, 2'b11);
      chk({pad_pci_gpio_oe_o, pad_pci_gpio_o, pci_shared_in_o}, {7'h07, 7'h7F, 7'h00});
      rdc(`PSM_ADDR_GPIO_EN, 32'hFF06);
      rdc(`PSM_ADDR_GPIO_IN, 32'h0F04);
      @(posedge clk_i);
      ext <= 8'hFF;
      rdc(`PSM_ADDR_GPIO_IN, 32'hFF06);
      // Only lane 1 enabled: the low byte of the output word must survive
      sel = 4'h2;
      wb(1'b0 | 1'b1, `PSM_ADDR_GPIO_OUT, 32'h0000);
      sel = 4'hF;
      rdc(`PSM_ADDR_GPIO_OUT, 32'h00FF);
      $display("gpio done");
   endtask
   task t_av;
      wb(1'b1, `PSM_ADDR_PERIPH_CFG, 32'h1);
      @(negedge clk_i);
      chk({pad_av_o, pad_av_oe_o, audio0_serial_data_pins_in_o, video1_data_pins_in_o}, 32'hA5FF00A5);
      rdc(`PSM_ADDR_STATUS, 32'h4);
      wb(1'b1, `PSM_ADDR_PERIPH_CFG, 32'h2);
      @(negedge clk_i);
      chk({pad_av_o, pad_av_oe_o, video1_data_pins_in_o, audio0_serial_data_pins_in_o}, 32'h3C0F00FC);
      rdc(`PSM_ADDR_STATUS, 32'h8);
      // New video pattern so the double-enable case proves live forwarding
      @(posedge clk_i);
      video1_data_pins_out_i <= 8'h5A;
      wb(1'b1, `PSM_ADDR_PERIPH_CFG, 32'h3);
      @(negedge clk_i);
      chk({video1_data_enable_o, audio0_data_enable_o, pad_av_o}, {2'b10, 8'h5A});
      wb(1'b1, `PSM_ADDR_PERIPH_CFG, 32'h4);
      @(negedge clk_i);
      chk(ethernet_enable_o, 1'b1);
      rdc(`PSM_ADDR_STATUS, 32'h2);
      // Config write without lane 0 must be dropped
      sel = 4'h2;
      wb(1'b1, `PSM_ADDR_PERIPH_CFG, 32'h0);
      sel = 4'hF;
      rdc(`PSM_ADDR_PERIPH_CFG, 32'h4);
      $display("av done");
   endtask
   task t_strap;
      do_reset(1'b1);
      chk({pci_enable_o, host_port_enable_o}, 2'b10);
      // Fresh PCI core patterns so pass-through is not a leftover
      @(posedge clk_i);
      pci_shared_out_i <= 7'h33;
      pci_solo_out_i <= 8'h96;
      // Functions chosen once right after reset and then left alone
      wb(1'b1, `PSM_ADDR_GPIO_EN, 32'hFFFF);
      wb(1'b1, `PSM_ADDR_GPIO_DIR, 32'hFFFF);
      wb(1'b1, `PSM_ADDR_PERIPH_CFG, 32'h4);
      @(negedge clk_i);
      chk({pad_gp8_oe_o, pad_gp8_o, ethernet_enable_o}, {1'b1, vcxo_control_output_i, 1'b0});
      chk({pad_pci_gpio_o, pad_pci_gpio_oe_o, pci_shared_in_o}, {7'h33, 7'h2A, 7'h77});
      chk({pad_pci_solo_o, pad_pci_solo_oe_o, pci_solo_in_o}, 24'h96F09F);
      rdc(`PSM_ADDR_STATUS, 32'h1);
      $display("strap done");
   endtask
   // Main sequence and watchdog
   initial begin
      do_reset(1'b0);
      t_defaults;
      t_gpio;
      t_av;
      t_strap;
      give_verdict;
   end
   initial begin
      #(3000 * 50);
      err_count++;
      $display("ERROR at %0t: watchdog expired", $time);
      give_verdict;
   end
endmodule // psm_top_tb_top
`default_nettype wire
